// ===== hw/cte_consts.svh
// Register offsets, field widths and reset values of the task and event block
`ifndef CTE_CONSTS_SVH
`define CTE_CONSTS_SVH
`define CTE_ADDR_W 12
`define CTE_OFF_KS_START 12'h000
`define CTE_OFF_CRYPT_START 12'h004
`define CTE_OFF_CRYPT_HALT 12'h008
`define CTE_OFF_RATE_REPLACE 12'h00C
`define CTE_OFF_KS_DONE 12'h100
`define CTE_OFF_CRYPT_DONE 12'h104
`define CTE_OFF_ERROR 12'h108
`define CTE_OFF_SHORTCUT 12'h200
`define CTE_OFF_MODE_RATE 12'h504
`define CTE_OFF_SPEED_SUB 12'h51C
`define CTE_OFF_STATUS 12'h600
`define CTE_RATE_W 2
`define CTE_RATE_RESET 2'h0
`define CTE_EVENT_RESET 1'h0
`endif

// ===== hw/cte_pkg.sv
// Types shared by the task and event block
`default_nettype none
package cte_pkg;
  typedef enum logic [2:0] {
    CTE_IDLE = 3'b001,
    CTE_KSGEN = 3'b010,
    CTE_CRYPT = 3'b100
  } cte_state_type;
endpackage
`default_nettype wire

// ===== hw/cte_task_event.sv
// Task and event register bank of the CCM engine
`include "cte_consts.svh"
`default_nettype none
module cte_task_event
  import cte_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ks_finished,
  input wire logic crypt_finished,
  input wire logic collision_error,
  output logic ks_run,
  output logic crypt_run,
  output logic dma_enable,
  output logic [1:0] link_speed_field
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Tasks act on bit 0 only; a zero write is a no-op
  wire logic wr_one = reg_wr && reg_wdata[0];
  wire logic ks_go = wr_one && (reg_addr == `CTE_OFF_KS_START);
  wire logic crypt_go_sw = wr_one && (reg_addr == `CTE_OFF_CRYPT_START);
  wire logic halt_go = wr_one && (reg_addr == `CTE_OFF_CRYPT_HALT);
  wire logic rate_go = wr_one && (reg_addr == `CTE_OFF_RATE_REPLACE);
  wire logic wr_ksd = reg_wr && (reg_addr == `CTE_OFF_KS_DONE);
  wire logic wr_crd = reg_wr && (reg_addr == `CTE_OFF_CRYPT_DONE);
  wire logic wr_err = reg_wr && (reg_addr == `CTE_OFF_ERROR);
  wire logic wr_short = reg_wr && (reg_addr == `CTE_OFF_SHORTCUT);
  wire logic wr_mode = reg_wr && (reg_addr == `CTE_OFF_MODE_RATE);
  wire logic wr_sub = reg_wr && (reg_addr == `CTE_OFF_SPEED_SUB);

  cte_state_type state_q, state_d;
  logic ksd_q, crd_q, err_q, short_q;
  logic [1:0] mode_rate_q, sub_q;

  // ----------------------------------------------------------------
  // Operation sequencing
  // ----------------------------------------------------------------
  wire logic ks_end = (state_q == CTE_KSGEN) && ks_finished;
  wire logic crypt_end = (state_q == CTE_CRYPT) && crypt_finished;
  wire logic short_go = ks_end && short_q;
  wire logic crypt_go = crypt_go_sw || short_go;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CTE_IDLE:
      begin
        if (ks_go)
          state_d = CTE_KSGEN;
        else if (crypt_go)
          state_d = CTE_CRYPT;
      end
      CTE_KSGEN:
      begin
        if (short_go)
          state_d = CTE_CRYPT;
        else if (ks_end)
          state_d = CTE_IDLE;
      end
      CTE_CRYPT:
      begin
        if (halt_go || crypt_end)
          state_d = CTE_IDLE;
      end
      default: state_d = CTE_IDLE;
    endcase
  end

  // Outputs flop the next state so they line up with state_q
  wire cte_state_type next_state = state_d;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_q <= CTE_IDLE;
    else
      state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // Events and settings; hardware set wins over software clear
  // ----------------------------------------------------------------
  wire logic ksd_d = ks_end ? 1'h1 : (wr_ksd ? reg_wdata[0] : ksd_q);
  wire logic crd_d = crypt_end ? 1'h1 : (wr_crd ? reg_wdata[0] : crd_q);
  wire logic err_d = collision_error ? 1'h1 : (wr_err ? reg_wdata[0] : err_q);
  wire logic [1:0] rate_d = rate_go ? sub_q : (wr_mode ? reg_wdata[1:0] : mode_rate_q);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ksd_q <= `CTE_EVENT_RESET;
      crd_q <= `CTE_EVENT_RESET;
      err_q <= `CTE_EVENT_RESET;
      short_q <= 1'h0;
      mode_rate_q <= `CTE_RATE_RESET;
      sub_q <= `CTE_RATE_RESET;
    end
    else
    begin
      ksd_q <= ksd_d;
      crd_q <= crd_d;
      err_q <= err_d;
      if (wr_short)
        short_q <= reg_wdata[0];
      if (wr_sub)
        sub_q <= reg_wdata[1:0];
      mode_rate_q <= rate_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  wire logic [31:0] rd_mux =
    (reg_addr == `CTE_OFF_KS_DONE) ? {31'h0, ksd_q} :
    (reg_addr == `CTE_OFF_CRYPT_DONE) ? {31'h0, crd_q} :
    (reg_addr == `CTE_OFF_ERROR) ? {31'h0, err_q} :
    (reg_addr == `CTE_OFF_SHORTCUT) ? {31'h0, short_q} :
    (reg_addr == `CTE_OFF_MODE_RATE) ? {30'h0, mode_rate_q} :
    (reg_addr == `CTE_OFF_SPEED_SUB) ? {30'h0, sub_q} :
    (reg_addr == `CTE_OFF_STATUS) ? {29'h0, state_q} : 32'h0;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      reg_rdata <= 32'h0;
      ks_run <= 1'h0;
      crypt_run <= 1'h0;
      dma_enable <= 1'h0;
      link_speed_field <= `CTE_RATE_RESET;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
      ks_run <= (next_state == CTE_KSGEN);
      crypt_run <= (next_state == CTE_CRYPT);
      dma_enable <= (next_state != CTE_IDLE);
      link_speed_field <= rate_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ks_done_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ks_end |=> ksd_q) else $error("keystream done not set");
  crypt_done_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
    crypt_end |=> crd_q) else $error("crypt done not set");
  ks_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == CTE_IDLE && ks_go) |=> ks_run && !crypt_run) else $error("keystream not started");
  crypt_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == CTE_IDLE && crypt_go_sw && !ks_go) |=> crypt_run) else $error("crypt not started");
  zero_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == CTE_IDLE && reg_wr && !reg_wdata[0]) |=> state_q == CTE_IDLE)
    else $error("zero write started work");
  halt_crypt_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == CTE_CRYPT && halt_go) |=> !crypt_run ##1 (!crypt_run || $past(crypt_go_sw)))
    else $error("halt ignored");
  rate_copy_a: assert property (@(posedge core_clk) disable iff (!nrst)
    rate_go |=> link_speed_field == $past(sub_q)) else $error("rate not replaced");
  shortcut_go_a: assert property (@(posedge core_clk) disable iff (!nrst)
    short_go |=> crypt_run && ksd_q) else $error("shortcut did not start crypt");
  dma_stop_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (crypt_end || (ks_end && !short_q)) |=> !dma_enable) else $error("memory access not stopped");
  error_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
    collision_error |=> err_q) else $error("error event not set");

  // Ends without a stop command; only one operation at a time
  ks_self_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ks_end && !short_q) |=> !ks_run && !crypt_run) else $error("keystream did not end");
  crypt_self_end_a: assert property (@(posedge core_clk) disable iff (!nrst)
    crypt_end |=> !crypt_run) else $error("crypt did not end");
  busy_ignore_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_q == CTE_KSGEN && crypt_go_sw && !ks_finished) |=> ks_run && !crypt_run)
    else $error("crypt start taken while busy");
  single_run_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !(ks_run && crypt_run)) else $error("two operations at once");
  dma_track_a: assert property (@(posedge core_clk) disable iff (!nrst)
    dma_enable == (ks_run || crypt_run)) else $error("memory access without operation");

  // Speed field moves only on a mode write or the replace task
  rate_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (!rate_go && !wr_mode) |=> $stable(link_speed_field)) else $error("speed field drifted");

  // Hardware never clears an event; software must
  ks_done_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (ksd_q && !wr_ksd) |=> ksd_q) else $error("keystream done lost");
  crypt_done_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (crd_q && !wr_crd) |=> crd_q) else $error("crypt done lost");
  error_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (err_q && !wr_err) |=> err_q) else $error("error event lost");

  // Read data stands one cycle only and carries the event bit
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read cycle");
  event_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (reg_rd && reg_addr == `CTE_OFF_CRYPT_DONE) |=> reg_rdata == {31'h0, $past(crd_q)})
    else $error("crypt done read wrong");

endmodule
`default_nettype wire

// ===== dv/cte_tb.sv
// Self-checking bench for the task and event register bank
`include "cte_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic ks_finished = 1'h0;
  logic crypt_finished = 1'h0;
  logic collision_error = 1'h0;
  logic [31:0] reg_rdata;
  logic ks_run;
  logic crypt_run;
  logic dma_enable;
  logic [1:0] link_speed_field;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  cte_task_event u_dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ks_finished(ks_finished), .crypt_finished(crypt_finished),
    .collision_error(collision_error), .ks_run(ks_run), .crypt_run(crypt_run),
    .dma_enable(dma_enable), .link_speed_field(link_speed_field));
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Runaway guard: the whole sequence needs well under this many cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  // One-cycle pulse on the datapath status inputs {error, crypt, keystream}
  task automatic pulse(input logic [2:0] k);
    @(posedge core_clk);
    {collision_error, crypt_finished, ks_finished} <= k;
    @(posedge core_clk);
    {collision_error, crypt_finished, ks_finished} <= 3'h0;
    #1;
  endtask
  task automatic t_crypt;
    wr(`CTE_OFF_CRYPT_START, 32'h0);
    chk({crypt_run, dma_enable}, 32'h0);
    wr(`CTE_OFF_CRYPT_START, 32'h1);
    chk({crypt_run, dma_enable}, 32'h3);
    rd(`CTE_OFF_CRYPT_START, 32'h0);
    pulse(3'h2);
    chk({crypt_run, dma_enable}, 32'h0);
    rd(`CTE_OFF_CRYPT_DONE, 32'h1);
    wr(`CTE_OFF_CRYPT_DONE, 32'h0);
    rd(`CTE_OFF_CRYPT_DONE, 32'h0);
  endtask
  task automatic t_ks;
    wr(`CTE_OFF_KS_START, 32'h1);
    chk({ks_run, dma_enable}, 32'h3);
    pulse(3'h1);
    chk({ks_run, crypt_run, dma_enable}, 32'h0);
    rd(`CTE_OFF_KS_DONE, 32'h1);
    wr(`CTE_OFF_KS_DONE, 32'h0);
  endtask
  task automatic t_halt_rate;
    wr(`CTE_OFF_MODE_RATE, 32'h1);
    chk({30'h0, link_speed_field}, 32'h1);
    wr(`CTE_OFF_CRYPT_START, 32'h1);
    wr(`CTE_OFF_SPEED_SUB, 32'h3);
    rd(`CTE_OFF_SPEED_SUB, 32'h3);
    chk({30'h0, link_speed_field}, 32'h1);
    wr(`CTE_OFF_RATE_REPLACE, 32'h1);
    @(posedge core_clk);
    #1 chk({crypt_run, link_speed_field}, 32'h7);
    rd(`CTE_OFF_MODE_RATE, 32'h3);
    wr(`CTE_OFF_CRYPT_HALT, 32'h0);
    chk({crypt_run, dma_enable}, 32'h3);
    wr(`CTE_OFF_CRYPT_HALT, 32'h1);
    chk({crypt_run, dma_enable}, 32'h0);
  endtask
  task automatic t_short_err;
    wr(`CTE_OFF_SHORTCUT, 32'h1);
    wr(`CTE_OFF_KS_START, 32'h1);
    pulse(3'h1);
    chk({ks_run, crypt_run}, 32'h1);
    pulse(3'h6);
    rd(`CTE_OFF_ERROR, 32'h1);
    rd(`CTE_OFF_CRYPT_DONE, 32'h1);
  endtask
  // Reset in the middle of a keystream run with every event set
  task automatic t_reset;
    wr(`CTE_OFF_KS_START, 32'h1);
    @(posedge core_clk);
    nrst <= 1'h0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    #1 chk({ks_run, crypt_run, dma_enable, link_speed_field}, 32'h0);
    rd(`CTE_OFF_KS_DONE, 32'h0);
    rd(`CTE_OFF_CRYPT_DONE, 32'h0);
    rd(`CTE_OFF_ERROR, 32'h0);
    rd(`CTE_OFF_STATUS, 32'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'h1;
    #1 chk({ks_run, crypt_run, dma_enable, link_speed_field}, 32'h0);
    rd(`CTE_OFF_KS_DONE, 32'h0);
    rd(`CTE_OFF_ERROR, 32'h0);
    t_crypt;
    t_ks;
    t_halt_rate;
    t_short_err;
    t_reset;
    stop_test;
  end
endmodule
`default_nettype wire
